// ---- include/fic_params.svh ----
// Constants for the flash information read command path
`ifndef FIC_PARAMS_SVH
`define FIC_PARAMS_SVH
// ==========================================================
// Opcodes
`define FIC_OP_ID         8'h9F
`define FIC_OP_QID        8'hAF
`define FIC_OP_PARAM      8'h5A
`define FIC_OP_SR1        8'h05
`define FIC_OP_SR2        8'h07
`define FIC_OP_CR1        8'h35
// ==========================================================
// Field positions and lengths on the device side
`define FIC_BUSY_BIT      0
`define FIC_QUAD_BIT      6
`define FIC_ADDR_BITS     6'h18
`define FIC_DUMMY_CYC     6'h08
`define FIC_BYTE_BITS     6'h08
// ==========================================================
// Host register offsets and fields
`define FIC_REG_CMD       12'h000
`define FIC_REG_ADDR      12'h004
`define FIC_REG_STAT      12'h008
`define FIC_REG_DATA      12'h00C
`define FIC_CMD_QUAD      8
`define FIC_CMD_HASADDR   9
`define FIC_CMD_NLSB      16
`define FIC_CMD_START     31
`define FIC_STAT_BUSY     0
`define FIC_STAT_DONE     1
`define FIC_CMD_RST       32'h0000_0000
// ==========================================================
// Timing
`define FIC_PCLK_NS       50
`define FIC_SCK_PERIOD_NS 800
`define FIC_SCK_HALF_CYC  ((`FIC_SCK_PERIOD_NS) / (2 * `FIC_PCLK_NS))
`endif

// ---- include/fic_pkg.sv ----
// Types shared by both ends of the information read path
package fic_pkg;
  // ==========================================================
  // Device decoder
  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DATA, PH_IGNORE} fic_phase_t;
  typedef enum logic [2:0] {CMD_NONE, CMD_ID, CMD_PARAM, CMD_SR1, CMD_SR2, CMD_CR1} fic_cmd_t;
  typedef struct packed {
    fic_phase_t  phase;
    fic_cmd_t    cmd;
    logic        quad;
    logic        ignored;
    logic        sck_q;
    logic [5:0]  cnt;
    logic [23:0] addr;
    logic [7:0]  shreg;
    logic [3:0]  io_o;
    logic [3:0]  oe_n;
  } fic_dev_state_t;
  // ==========================================================
  // Host controller
  typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH} fic_hphase_t;
  typedef struct packed {
    fic_hphase_t ph;
    logic        cs_n;
    logic        sck;
    logic [3:0]  io_o;
    logic [3:0]  oe_n;
    logic [3:0]  div;
    logic [7:0]  cyc;
    logic        quad;
    logic        done;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [31:0] cmd;
    logic [23:0] addr;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fic_host_state_t;
endpackage

// ---- include/fic_link_if.sv ----
// Serial link between the host controller and the flash device
`timescale 1ns/1ps
interface fic_link_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe_n;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe_n;
  logic [3:0] io;
  // Wire level of the four data lines, pulled high when nobody drives
  assign io = (~dev_io_oe_n & dev_io_o) | (~host_io_oe_n & host_io_o) | (dev_io_oe_n & host_io_oe_n);
  modport device (
    input  cs_n,
    input  sck,
    input  io,
    output dev_io_o,
    output dev_io_oe_n
  );
  modport host (
    output cs_n,
    output sck,
    output host_io_o,
    output host_io_oe_n,
    input  io
  );
endinterface // fic_link_if

// ---- rtl/fic_sync.sv ----
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module fic_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  // ==========================================================
  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // fic_sync

// ---- rtl/fic_device.sv ----
// Device end: decoder for the flash information read commands
`timescale 1ns/1ps
`include "fic_params.svh"
// ==========================================================
// Notes on behaviour
// RULE_01 - 9Fh returns identification table bytes serially
// RULE_02 - Identification ignored while embedded operation busy
// RULE_03 - Chip select ends read; overrun data undefined
// RULE_04 - Host keeps identification clock within 133 MHz
// RULE_05 - Quad mode: 9Fh on four lines
// RULE_06 - AFh only in quad mode, four lines
// RULE_07 - Host keeps quad identification within 133 MHz
// RULE_08 - 5Ah, 24-bit address, 8 dummies, data
// RULE_09 - Parameter bytes leave most significant first
// RULE_10 - Parameter read starts at given address
// RULE_11 - Host keeps parameter read within 50 MHz
// RULE_12 - Quad mode: parameter read on four lines
// RULE_13 - 05h returns status one even when busy
// RULE_14 - Status one repeats, refreshed every byte
// RULE_15 - Host keeps status one read within 133 MHz
// RULE_16 - Quad status one: two cycles per byte
// RULE_17 - 07h returns status two, repeating, anytime
// RULE_18 - Quad host reads status two otherwise
// RULE_19 - 35h returns config one, repeating, anytime
// RULE_20 - Quad host reads config one otherwise
// RULE_21 - Status one bit zero shows busy
// RULE_22 - Chip select high releases lines, decoder idle
module fic_device #(
  // Identification table, value arbitrary
  parameter logic [127:0] ID_TABLE    = 128'h1122_3344_5566_7788_99AA_BBCC_DDEE_FF00,
  // Parameter table, value arbitrary
  parameter logic [127:0] PARAM_TABLE = 128'h5346_4450_0601_00FF_0000_0106_1000_00FF
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  fic_link_if.device            link,
  input  wire logic             busy,
  input  wire logic [7:0]       status_one_volatile,
  input  wire logic [7:0]       status_two,
  input  wire logic [7:0]       config_one_volatile,
  input  wire logic [7:0]       config_two_volatile,
  output fic_pkg::fic_cmd_t     cmd_active,
  output logic                  cmd_ignored
);

  fic_pkg::fic_dev_state_t s;
  fic_pkg::fic_dev_state_t next_s;
  logic [5:0]              sync_q;
  logic                    cs_s;
  logic                    sck_s;
  logic [3:0]              io_s;
  logic                    rise;
  logic                    fall;
  logic [5:0]              step;
  logic [7:0]              byte_now;
  logic [7:0]              status_one_live;

  // ==========================================================
  // Pin synchronisers
  // Reset image: chip select high, clock low, lines pulled up
  fic_sync #(
    .W       (6),
    .RST_VAL (6'h2F)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       ({link.cs_n, link.sck, link.io}),
    .q       (sync_q)
  );

  // Split synchronised pins and find clock edges
  assign cs_s  = sync_q[5];
  assign sck_s = sync_q[4];
  assign io_s  = sync_q[3:0];
  assign rise  = sck_s & ~s.sck_q;
  assign fall  = ~sck_s & s.sck_q;
  // Quad mode moves a nibble per cycle
  assign step  = s.quad ? 6'h04 : 6'h01;

  // ==========================================================
  // Live status one with the busy flag folded in
  // RULE_21 busy flag bit
  assign status_one_live = {status_one_volatile[7:1], busy};

  // ==========================================================
  // Byte source for the data phase
  always_comb begin
    byte_now = s.shreg;
    if (s.cnt == 6'h00) begin
      case (s.cmd)
        // RULE_01 identification table bytes
        fic_pkg::CMD_ID:    byte_now = ID_TABLE[8*(15-s.addr[3:0]) +: 8];
        // RULE_10 start at chosen address
        fic_pkg::CMD_PARAM: byte_now = PARAM_TABLE[8*(15-s.addr[3:0]) +: 8];
        // RULE_14 fresh value each byte
        fic_pkg::CMD_SR1:   byte_now = status_one_live;
        // RULE_17 status two repeats
        fic_pkg::CMD_SR2:   byte_now = status_two;
        // RULE_19 config one repeats
        fic_pkg::CMD_CR1:   byte_now = config_one_volatile;
        default:            byte_now = 8'hFF;
      endcase
    end
  end

  // ==========================================================
  // Decoder next state
  always_comb begin
    next_s       = s;
    next_s.sck_q = sck_s;
    if (cs_s) begin
      // RULE_22 release lines, back to opcode
      next_s.phase   = fic_pkg::PH_OPCODE;
      next_s.cmd     = fic_pkg::CMD_NONE;
      next_s.cnt     = 6'h00;
      next_s.addr    = 24'h00_0000;
      next_s.ignored = 1'b0;
      next_s.oe_n    = 4'hF;
      next_s.io_o    = 4'hF;
      // Mode is frozen for the whole frame
      next_s.quad    = config_two_volatile[`FIC_QUAD_BIT];
    end else if (rise) begin
      case (s.phase)
        fic_pkg::PH_OPCODE: begin
          // RULE_05 opcode on four lines in quad mode
          next_s.shreg = s.quad ? {s.shreg[3:0], io_s} : {s.shreg[6:0], io_s[0]};
          next_s.cnt   = s.cnt + step;
          if (next_s.cnt == `FIC_BYTE_BITS) begin
            next_s.cnt   = 6'h00;
            next_s.phase = fic_pkg::PH_DATA;
            case (next_s.shreg)
              `FIC_OP_ID: begin
                next_s.cmd = fic_pkg::CMD_ID;
              end
              `FIC_OP_QID: begin
                // RULE_06 recognised only in quad mode
                next_s.cmd = s.quad ? fic_pkg::CMD_ID : fic_pkg::CMD_NONE;
              end
              `FIC_OP_PARAM: begin
                // RULE_08 address phase follows
                next_s.cmd   = fic_pkg::CMD_PARAM;
                next_s.phase = fic_pkg::PH_ADDR;
              end
              `FIC_OP_SR1: begin
                // RULE_13 honoured even while busy
                next_s.cmd = fic_pkg::CMD_SR1;
              end
              `FIC_OP_SR2: begin
                // RULE_18 not served in quad mode
                next_s.cmd = s.quad ? fic_pkg::CMD_NONE : fic_pkg::CMD_SR2;
              end
              `FIC_OP_CR1: begin
                // RULE_20 not served in quad mode
                next_s.cmd = s.quad ? fic_pkg::CMD_NONE : fic_pkg::CMD_CR1;
              end
              default: begin
                next_s.cmd = fic_pkg::CMD_NONE;
              end
            endcase
            // RULE_02 identification dropped while busy
            if (busy && next_s.cmd == fic_pkg::CMD_ID) begin
              next_s.cmd = fic_pkg::CMD_NONE;
            end
            if (next_s.cmd == fic_pkg::CMD_NONE) begin
              next_s.phase   = fic_pkg::PH_IGNORE;
              next_s.ignored = 1'b1;
            end
          end
        end
        fic_pkg::PH_ADDR: begin
          // RULE_12 address nibbles in quad mode
          next_s.addr = s.quad ? {s.addr[19:0], io_s} : {s.addr[22:0], io_s[0]};
          next_s.cnt  = s.cnt + step;
          if (next_s.cnt == `FIC_ADDR_BITS) begin
            next_s.cnt   = 6'h00;
            next_s.phase = fic_pkg::PH_DUMMY;
          end
        end
        fic_pkg::PH_DUMMY: begin
          // RULE_08 eight dummy cycles
          next_s.cnt = s.cnt + 6'h01;
          if (next_s.cnt == `FIC_DUMMY_CYC) begin
            next_s.cnt   = 6'h00;
            next_s.phase = fic_pkg::PH_DATA;
          end
        end
        fic_pkg::PH_DATA: begin
          next_s.cnt = s.cnt;
        end
        fic_pkg::PH_IGNORE: begin
          next_s.cnt = s.cnt;
        end
        default: begin
          next_s.phase = fic_pkg::PH_IGNORE;
        end
      endcase
    end else if (fall && s.phase == fic_pkg::PH_DATA) begin
      // RULE_08 first bit on the falling edge after the last input cycle
      if (s.cnt == 6'h00 && (s.cmd == fic_pkg::CMD_ID || s.cmd == fic_pkg::CMD_PARAM)) begin
        // Table wraps at its end; output there counts as undefined
        next_s.addr = s.addr + 24'h00_0001;
      end
      if (s.quad) begin
        // RULE_16 high nibble then low nibble
        next_s.io_o  = byte_now[7:4];
        next_s.oe_n  = 4'h0;
        next_s.shreg = {byte_now[3:0], 4'h0};
      end else begin
        // RULE_09 most significant bit first
        next_s.io_o  = {2'h3, byte_now[7], 1'b1};
        next_s.oe_n  = 4'hD;
        next_s.shreg = {byte_now[6:0], 1'b0};
      end
      next_s.cnt = s.cnt + step;
      if (next_s.cnt == `FIC_BYTE_BITS) begin
        // RULE_14 next byte reloads the source
        next_s.cnt = 6'h00;
      end
    end
  end

  // ==========================================================
  // State register; clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.phase   <= fic_pkg::PH_OPCODE;
      s.cmd     <= fic_pkg::CMD_NONE;
      s.quad    <= 1'b0;
      s.ignored <= 1'b0;
      s.sck_q   <= 1'b0;
      s.cnt     <= 6'h00;
      s.addr    <= 24'h00_0000;
      s.shreg   <= 8'h00;
      s.io_o    <= 4'hF;
      s.oe_n    <= 4'hF;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs straight from the state flops
  // RULE_03 lines follow chip select only
  assign link.dev_io_o    = s.io_o;
  assign link.dev_io_oe_n = s.oe_n;
  assign cmd_active       = s.cmd;
  assign cmd_ignored      = s.ignored;

endmodule // fic_device

// ---- rtl/fic_host.sv ----
// Host end: APB-controlled issuer of information read commands
`timescale 1ns/1ps
`include "fic_params.svh"
module fic_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  fic_link_if.host         link
);

  fic_pkg::fic_host_state_t s;
  fic_pkg::fic_host_state_t next_s;
  logic [3:0]               io_s;
  logic                     half_end;
  logic                     wr_en;
  logic [2:0]               nbytes;
  logic                     has_addr;
  logic                     quad;
  logic [7:0]               n_tx;
  logic [7:0]               n_rx0;

  // ==========================================================
  // Data lines come from the far end
  fic_sync #(
    .W       (4),
    .RST_VAL (4'hF)
  ) u_io_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (link.io),
    .q       (io_s)
  );

  // RULE_04 slow divided clock, also for RULE_07 and RULE_15
  // RULE_11 well under the parameter read limit
  assign half_end = (s.div == 4'((`FIC_SCK_HALF_CYC) - 1));
  assign wr_en    = psel & penable & s.pready & pwrite;
  assign quad     = s.cmd[`FIC_CMD_QUAD];
  assign has_addr = s.cmd[`FIC_CMD_HASADDR];
  assign nbytes   = s.cmd[`FIC_CMD_NLSB +: 3];
  // RULE_08 send cycles, then dummies before data
  assign n_tx     = quad ? (has_addr ? 8'h08 : 8'h02) : (has_addr ? 8'h20 : 8'h08);
  assign n_rx0    = n_tx + (has_addr ? 8'(`FIC_DUMMY_CYC) : 8'h00);

  // ==========================================================
  // Next state: register bus and link sequencer
  always_comb begin
    next_s         = s;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    // Setup cycle prepares the answer for the access cycle
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      case (paddr)
        `FIC_REG_CMD:  next_s.prdata = {1'b0, s.cmd[30:0]};
        `FIC_REG_ADDR: next_s.prdata = {8'h00, s.addr};
        `FIC_REG_STAT: next_s.prdata = {30'h0000_0000, s.done, s.ph != fic_pkg::HS_IDLE};
        `FIC_REG_DATA: next_s.prdata = s.rx;
        default: begin
          next_s.prdata  = 32'h0000_0000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_en && paddr == `FIC_REG_ADDR && s.ph == fic_pkg::HS_IDLE) begin
      next_s.addr = pwdata[23:0];
    end
    case (s.ph)
      fic_pkg::HS_IDLE: begin
        // Start bit launches a frame; writes while running are dropped
        if (wr_en && paddr == `FIC_REG_CMD) begin
          next_s.cmd = pwdata;
          if (pwdata[`FIC_CMD_START]) begin
            next_s.ph   = fic_pkg::HS_LOW;
            next_s.cs_n = 1'b0;
            next_s.sck  = 1'b0;
            next_s.div  = 4'h0;
            next_s.cyc  = 8'h00;
            next_s.done = 1'b0;
            next_s.rx   = 32'h0000_0000;
            next_s.tx   = {pwdata[7:0], s.addr};
            next_s.quad = pwdata[`FIC_CMD_QUAD];
            if (pwdata[`FIC_CMD_QUAD]) begin
              next_s.io_o = pwdata[7:4];
              next_s.oe_n = 4'h0;
              next_s.tx   = {pwdata[3:0], s.addr, 4'h0};
            end else begin
              next_s.io_o = {3'h7, pwdata[7]};
              next_s.oe_n = 4'hE;
              next_s.tx   = {pwdata[6:0], s.addr, 1'b0};
            end
          end
        end
      end
      fic_pkg::HS_LOW: begin
        next_s.div = s.div + 4'h1;
        if (half_end) begin
          next_s.div = 4'h0;
          next_s.sck = 1'b1;
          next_s.ph  = fic_pkg::HS_HIGH;
          // Sample returned data on the rising edge
          if (s.cyc >= n_rx0) begin
            next_s.rx = s.quad ? {s.rx[27:0], io_s} : {s.rx[30:0], io_s[1]};
          end
        end
      end
      fic_pkg::HS_HIGH: begin
        next_s.div = s.div + 4'h1;
        if (half_end) begin
          next_s.div = 4'h0;
          next_s.sck = 1'b0;
          next_s.cyc = s.cyc + 8'h01;
          next_s.ph  = fic_pkg::HS_LOW;
          if (s.cyc + 8'h01 >= n_rx0 + (s.quad ? {4'h0, nbytes, 1'b0} : {2'h0, nbytes, 3'h0})) begin
            // RULE_03 chip select ends the read
            next_s.ph   = fic_pkg::HS_IDLE;
            next_s.cs_n = 1'b1;
            next_s.oe_n = 4'hF;
            next_s.done = 1'b1;
          end else if (s.cyc + 8'h01 < n_tx) begin
            next_s.io_o = s.quad ? s.tx[31:28] : {3'h7, s.tx[31]};
            next_s.tx   = s.quad ? {s.tx[27:0], 4'h0} : {s.tx[30:0], 1'b0};
          end else begin
            // Lines released before the device turns them round
            next_s.oe_n = 4'hF;
          end
        end
      end
      default: begin
        next_s.ph = fic_pkg::HS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s      <= '0;
      s.ph   <= fic_pkg::HS_IDLE;
      s.cs_n <= 1'b1;
      s.io_o <= 4'hF;
      s.oe_n <= 4'hF;
      s.cmd  <= `FIC_CMD_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Outputs from flops
  assign prdata            = s.prdata;
  assign pready            = s.pready;
  assign pslverr           = s.pslverr;
  assign link.cs_n         = s.cs_n;
  assign link.sck          = s.sck;
  assign link.host_io_o    = s.io_o;
  assign link.host_io_oe_n = s.oe_n;

endmodule // fic_host

// ---- bench/fic_link_properties.sv ----
// Link checker for the flash information read path
`timescale 1ns/1ps
// ==========================================================
// Checker on the shared link
module fic_link_properties (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] host_io_oe_n,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe_n
);
  logic [7:0] rises;
  logic       sck_q;
  // Rising clocks in a frame, saturating so long frames never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rises <= 8'h00;
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck;
      rises <= cs_n ? 8'h00 : rises + {7'h00, sck && !sck_q && rises != 8'hFF};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RELEASE: assert property ($rose(cs_n) |-> ##[1:5] dev_io_oe_n == 4'hF)
    else $error("device still drives after frame end");
  AST_IDLE_QUIET: assert property (cs_n [*6] |-> dev_io_oe_n == 4'hF)
    else $error("device drives between frames");
  AST_SCK_IN_FRAME: assert property ($changed(sck) |-> !$past(cs_n))
    else $error("serial clock moves outside a frame");
  AST_IDLE_LOW: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  AST_SERIAL_AFTER_OP: assert property (!cs_n && dev_io_oe_n == 4'hD |-> rises >= 8'h08)
    else $error("serial output before opcode complete");
  AST_QUAD_AFTER_OP: assert property (!cs_n && dev_io_oe_n == 4'h0 |-> rises >= 8'h02)
    else $error("quad output before opcode complete");
  AST_LANES: assert property (dev_io_oe_n inside {4'hF, 4'hD, 4'h0})
    else $error("device drives an unexpected lane set");
  AST_NO_FIGHT: assert property (((~dev_io_oe_n) & (~host_io_oe_n)) == 4'h0)
    else $error("both ends drive one line");
  AST_DATA_HOLD: assert property ($rose(sck) && dev_io_oe_n != 4'hF |-> $stable(dev_io_o))
    else $error("device data moves at the sampling edge");
  CV_SERIAL: cover property (!cs_n && dev_io_oe_n == 4'hD);
  CV_QUAD: cover property (!cs_n && dev_io_oe_n == 4'h0);
  CV_END: cover property ($rose(cs_n));
endmodule // fic_link_properties

// ---- bench/tb_flash_id_status_read_cmds.sv ----
// Testbench joining host and device ends of the information read path
`timescale 1ns/1ps
`include "fic_params.svh"
module tb_flash_id_status_read_cmds;
  // ==========================================================
  // Signals and tables (table values arbitrary)
  localparam logic [127:0] ID_T  = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  localparam logic [127:0] PRM_T = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
  localparam logic [7:0]   OPS [6] = '{8'h9F, 8'hAF, 8'h5A, 8'h05, 8'h07, 8'h35};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic [7:0]  s1;
  logic [7:0]  s2;
  logic [7:0]  c1;
  logic [7:0]  c2;
  int          failures;
  int          tests_run;
  int          seed;
  int          nrise = 0;
  logic        ign_last;
  logic        cmd_ignored;
  fic_pkg::fic_cmd_t cmd_active;
  fic_pkg::fic_cmd_t act_last;
  fic_link_if link ();
  fic_host fic_host_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.host));
  fic_device #(.ID_TABLE(ID_T), .PARAM_TABLE(PRM_T)) fic_device_i (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .link(link.device), .busy(busy), .status_one_volatile(s1), .status_two(s2),
    .config_one_volatile(c1), .config_two_volatile(c2), .cmd_active(cmd_active), .cmd_ignored(cmd_ignored));
  fic_link_properties fic_link_properties_i (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
    .sck(link.sck), .host_io_oe_n(link.host_io_oe_n), .dev_io_o(link.dev_io_o),
    .dev_io_oe_n(link.dev_io_oe_n));
  // Clock and wire activity counter
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Decoder outputs stand long before the last rise of any frame
  always @(posedge link.sck) begin
    nrise    <= nrise + 1;
    ign_last <= cmd_ignored;
    act_last <= cmd_active;
  end
  // Opcodes the device must refuse in this mode and busy state
  function automatic logic refused(logic [7:0] op, logic q, logic b);
    return !(op inside {8'h9F, 8'hAF, 8'h5A, 8'h05, 8'h07, 8'h35}) || ((op == 8'h9F || op == 8'hAF) && b)
           || (op == 8'hAF && !q) || ((op == 8'h07 || op == 8'h35) && q);
  endfunction
  function automatic fic_pkg::fic_cmd_t exp_cmd(logic [7:0] op, logic q, logic b);
    if (refused(op, q, b))
      return fic_pkg::CMD_NONE;
    case (op)
      8'h9F, 8'hAF: return fic_pkg::CMD_ID;
      8'h5A:        return fic_pkg::CMD_PARAM;
      8'h05:        return fic_pkg::CMD_SR1;
      8'h07:        return fic_pkg::CMD_SR2;
      default:      return fic_pkg::CMD_CR1;
    endcase
  endfunction
  // ==========================================================
  // Expected byte; refused commands leave the pulled-up lines at ones
  function automatic logic [7:0] exp_byte(logic [7:0] op, logic q, logic b, int k, logic [23:0] a);
    if (refused(op, q, b))
      return 8'hFF;
    case (op)
      8'h9F, 8'hAF: return ID_T[8 * (15 - k) +: 8];
      8'h5A: return PRM_T[8 * (15 - (a[3:0] + k) % 16) +: 8];
      8'h05: return {s1[7:1], b};
      8'h07: return s2;
      default: return c1;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // APB transfer; waits for pready, only the watchdog bounds it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One frame: set device inputs, start, wait done, compare data and clock count
  task automatic run(input logic [7:0] op, input logic q, input logic b, input int n, input logic [23:0] a);
    logic [31:0] r;
    logic        e;
    logic [31:0] w;
    logic        ha;
    int          k;
    int          r0;
    ha = (op == 8'h5A);
    @(posedge pclk);
    busy <= b;
    s1 <= 8'($random(seed));
    s2 <= 8'($random(seed));
    c1 <= 8'($random(seed));
    c2 <= (8'($random(seed)) & 8'hBF) | {1'b0, q, 6'h00};
    repeat (4) @(posedge pclk);
    w = 32'h0;
    for (k = 0; k < n; k++) w = {w[23:0], exp_byte(op, q, b, k, a)};
    r0 = nrise;
    apb(1'b1, `FIC_REG_ADDR, {8'h00, a}, r, e);
    apb(1'b1, `FIC_REG_CMD, {1'b1, 12'h000, 3'(n), 6'h00, ha, q, op}, r, e);
    r = 32'h0;
    while (r[1] !== 1'b1) begin
      apb(1'b0, `FIC_REG_STAT, 32'h0, r, e);
    end
    apb(1'b0, `FIC_REG_DATA, 32'h0, r, e);
    chk("data", w, r & ((n == 4) ? 32'hFFFF_FFFF : (32'h1 << (8 * n)) - 32'h1));
    chk("sck rises", (q ? 2 : 8) * (1 + n) + (ha ? (q ? 14 : 32) : 0), nrise - r0);
    chk("ignored", {31'h0, refused(op, q, b)}, {31'h0, ign_last});
    chk("command", 32'(exp_cmd(op, q, b)), 32'(act_last));
    $display("test op %h quad %0d busy %0d bytes %0d done", op, q, b, n);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (80000) @(posedge pclk);
    failures++;
    complete_run();
  end
  // ==========================================================
  // Main sequence: corner cases, then random frames
  initial begin
    logic [31:0] r;
    logic        e;
    int          i;
    seed = 32'ha64bf629;
    failures = 0;
    tests_run = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, busy, s1, s2, c1, c2} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    run(8'h05, 1'b0, 1'b1, 1, 24'h0);
    run(8'h05, 1'b0, 1'b0, 3, 24'h0);
    run(8'h07, 1'b0, 1'b1, 2, 24'h0);
    run(8'h35, 1'b0, 1'b1, 2, 24'h0);
    run(8'h9F, 1'b0, 1'b0, 4, 24'h0);
    run(8'h9F, 1'b0, 1'b1, 2, 24'h0);
    run(8'hAF, 1'b0, 1'b0, 1, 24'h0);
    run(8'h5A, 1'b0, 1'b0, 4, 24'h0);
    run(8'h5A, 1'b0, 1'b1, 4, 24'h00000E);
    run(8'h9F, 1'b1, 1'b0, 4, 24'h0);
    run(8'hAF, 1'b1, 1'b0, 3, 24'h0);
    run(8'h5A, 1'b1, 1'b0, 2, 24'h123457);
    run(8'h05, 1'b1, 1'b1, 4, 24'h0);
    run(8'h07, 1'b1, 1'b0, 1, 24'h0);
    run(8'h35, 1'b1, 1'b0, 1, 24'h0);
    run(8'h3C, 1'b0, 1'b0, 1, 24'h0);
    for (i = 0; i < 8; i++)
      run(OPS[{$random(seed)} % 6], 1'($random(seed)), 1'($random(seed)), 1 + {$random(seed)} % 4,
          24'($random(seed)));
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    complete_run();
  end
endmodule // tb_flash_id_status_read_cmds
